// file: mpp_map.vh
// Constants for the muxed parallel memory port
`ifndef MPP_MAP_VH
`define MPP_MAP_VH
`define MPP_ST_IDLE 3'h0
`define MPP_ST_ADDR 3'h1
`define MPP_ST_ALAT 3'h2
`define MPP_ST_DATA 3'h3
`define MPP_ST_DONE 3'h4
`define MPP_DATA_CYC_RST 5'h02
`define MPP_ALE_POL_RST 1'b1
`endif

// file: mpp_mem_model.sv
// Behavioural external memory with address latch
`timescale 1ns/1ps
module mpp_mem_model (
    input wire sys_clk_i, ale_active_low_i, oe_i, rd_b_i, wr_b_i, ale_i,
    input wire [15:0] pins_o_i,
    output wire [15:0] pins_i_o,
    output reg [15:0] last_wr_o
);
    reg [15:0] lat_r = 16'h0000;
    // Released bus floats to the pull-up level
    assign pins_i_o = oe_i ? pins_o_i : (rd_b_i ? 16'hffff : lat_r ^ 16'h5a5a);
    always @(posedge sys_clk_i) begin
        if (ale_i ^ ale_active_low_i)
            lat_r <= pins_o_i;
        if (!wr_b_i)
            last_wr_o <= pins_o_i;
    end
endmodule // mpp_mem_model

// file: mpp_port.v
// Muxed address/data parallel memory port, pin-level sequencer
`timescale 1ns/1ps
`include "mpp_map.vh"
////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Shared pins carry address or data; latch strobe level marks which.
// - Byte-wide and halfword-wide modes selectable.
// - Byte mode pulses latch strobe when upper address bits change.
// - Latch strobe asserted whenever a new address is placed on pins.
// - Latch strobe active-high after reset; software may make it active-low.
// - Read strobe low during every read, high otherwise.
// - Write strobe low during every write, high otherwise.
// - In flag use all three strobes stay deasserted.
// - Shared pins undriven during and after reset until configured.
module mpp_port #(
    parameter DATA_CYC_W = 5
) (
    // Clock and reset
    input wire sys_clk_i,
    input wire rst_b_i,
    // Configuration
    input wire port_en_i,
    input wire flag_mode_i,
    input wire wide_mode_i,
    input wire ale_active_low_i,
    input wire [DATA_CYC_W-1:0] data_cycles_i,
    // Access request
    input wire req_valid_i,
    input wire req_write_i,
    input wire [23:0] req_addr_i,
    input wire [15:0] req_wdata_i,
    output reg req_ready_o,
    output reg rsp_valid_o,
    output reg [15:0] rsp_rdata_o,
    // Pins
    input wire [15:0] shared_addr_data_pins_i,
    output reg [15:0] shared_addr_data_pins_o,
    output reg shared_addr_data_pins_oe_o,
    output reg rd_b_o,
    output reg wr_b_o,
    output reg ale_o
);

////////////////////////////////////////////////////////////////////////////////
// State codes
localparam [2:0] ST_IDLE = 3'b000;
localparam [2:0] ST_ADDR = 3'b001;
localparam [2:0] ST_ALAT = 3'b010;
localparam [2:0] ST_DATA = 3'b011;
localparam [2:0] ST_DONE = 3'b100;

// Sequencer state
reg [2:0] state_r;
reg [DATA_CYC_W-1:0] cnt_r;
reg write_r;
reg wide_r;

// Captured request
reg [15:0] addr_lo_r;
reg [15:0] wdata_r;

// Copy of the external upper address latch
reg [15:0] upper_address_bits_r;
reg upper_valid_r;
reg ale_pol_r;

// Pin input synchroniser
reg [15:0] din_s1_r;
reg [15:0] din_s2_r;
reg [15:0] din_s3_r;
reg [15:0] din_q_r;

wire cfg_ok = port_en_i && !flag_mode_i;
wire [DATA_CYC_W-1:0] cyc_min = {{(DATA_CYC_W-1){1'b0}}, 1'b1};
wire [DATA_CYC_W-1:0] cyc_load = (data_cycles_i == {DATA_CYC_W{1'b0}})
    ? cyc_min : data_cycles_i;

// Byte mode needs an upper latch phase only on a change or first use
wire need_upper = !wide_mode_i
    && (!upper_valid_r || upper_address_bits_r != req_addr_i[23:8]);

// Request taken on this edge
wire take = cfg_ok && req_valid_i && req_ready_o;

////////////////////////////////////////////////////////////////////////////////
// Per-bit synchroniser; a pin level counts once stages two and three agree
// Limitation: read data needs at least five strobe cycles to pass it
genvar gi;

generate
    for (gi = 0; gi < 16; gi = gi + 1) begin : g_din
        always @(posedge sys_clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
                din_s1_r[gi] <= 1'b1;
                din_s2_r[gi] <= 1'b1;
                din_s3_r[gi] <= 1'b1;
                din_q_r[gi] <= 1'b1;
            end else begin
                din_s1_r[gi] <= shared_addr_data_pins_i[gi];
                din_s2_r[gi] <= din_s1_r[gi];
                din_s3_r[gi] <= din_s2_r[gi];
                if (din_s2_r[gi] == din_s3_r[gi]) begin
                    din_q_r[gi] <= din_s3_r[gi];
                end
            end
        end
    end
endgenerate

////////////////////////////////////////////////////////////////////////////////
always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
        state_r <= ST_IDLE;
        cnt_r <= {DATA_CYC_W{1'b0}};
        write_r <= 1'b0;
        wide_r <= 1'b0;

        addr_lo_r <= 16'h0000;
        upper_address_bits_r <= 16'h0000;
        upper_valid_r <= 1'b0;
        wdata_r <= 16'h0000;
        ale_pol_r <= `MPP_ALE_POL_RST;

        req_ready_o <= 1'b0;
        rsp_valid_o <= 1'b0;
        rsp_rdata_o <= 16'h0000;

        shared_addr_data_pins_o <= 16'h0000;
        shared_addr_data_pins_oe_o <= 1'b0;
        rd_b_o <= 1'b1;
        wr_b_o <= 1'b1;
        ale_o <= 1'b0;
    end else begin
        // Single-cycle outputs fall back unless a state raises them
        rsp_valid_o <= 1'b0;
        req_ready_o <= 1'b0;

        case (state_r)
        ST_IDLE: begin
            rd_b_o <= 1'b1;
            wr_b_o <= 1'b1;
            // Polarity only changes between accesses to avoid a glitch pulse
            ale_pol_r <= !ale_active_low_i;
            ale_o <= ale_active_low_i;

            if (!cfg_ok) begin
                shared_addr_data_pins_oe_o <= 1'b0;
                upper_valid_r <= 1'b0;
            end else begin
                req_ready_o <= 1'b1;
                if (take) begin
                    req_ready_o <= 1'b0;
                    write_r <= req_write_i;
                    wide_r <= wide_mode_i;
                    addr_lo_r <= wide_mode_i ? req_addr_i[15:0] : {8'h00, req_addr_i[7:0]};
                    wdata_r <= req_wdata_i;
                    shared_addr_data_pins_oe_o <= 1'b1;
                    ale_o <= ale_pol_r;
                    if (need_upper) begin
                        upper_address_bits_r <= req_addr_i[23:8];
                        upper_valid_r <= 1'b1;
                        shared_addr_data_pins_o <= req_addr_i[23:8];
                        state_r <= ST_ALAT;
                    end else begin
                        shared_addr_data_pins_o <= wide_mode_i ? req_addr_i[15:0]
                            : {8'h00, req_addr_i[7:0]};
                        state_r <= ST_ADDR;
                    end
                end
            end
        end

        ST_ALAT: begin
            // Upper latch pulse ends, then the low address gets its own pulse
            ale_o <= ~ale_pol_r;
            shared_addr_data_pins_o <= addr_lo_r;
            state_r <= ST_DONE;
        end

        ST_DONE: begin
            ale_o <= ale_pol_r;
            state_r <= ST_ADDR;
        end

        ST_ADDR: begin
            ale_o <= ~ale_pol_r;
            cnt_r <= cyc_load;
            // Pins keep the write data afterwards; a read frees them at once
            if (write_r) begin
                shared_addr_data_pins_o <= wide_r ? wdata_r : {8'h00, wdata_r[7:0]};
                wr_b_o <= 1'b0;
            end else begin
                shared_addr_data_pins_oe_o <= 1'b0;
                rd_b_o <= 1'b0;
            end
            state_r <= ST_DATA;
        end

        ST_DATA: begin
            if (cnt_r == cyc_min) begin
                rd_b_o <= 1'b1;
                wr_b_o <= 1'b1;
                // Byte reads return only the low lane
                if (!write_r) begin
                    rsp_rdata_o <= wide_r ? din_q_r : {8'h00, din_q_r[7:0]};
                end
                rsp_valid_o <= 1'b1;
                state_r <= ST_IDLE;
            end else begin
                cnt_r <= cnt_r - cyc_min;
            end
        end

        default: begin
            state_r <= ST_IDLE;
        end
        endcase
    end
end

endmodule // mpp_port

// file: mpp_port_chk.sv
// Pin-level assertions for the muxed memory port
`timescale 1ns/1ps
module mpp_port_chk #(parameter DATA_CYC_W = 5) (
    // Clock, reset and configuration
    input wire sys_clk_i, rst_b_i, port_en_i, flag_mode_i, wide_mode_i, ale_active_low_i,
    input wire [DATA_CYC_W-1:0] data_cycles_i,
    // Requests
    input wire req_valid_i, req_write_i, req_ready_o, rsp_valid_o,
    input wire [23:0] req_addr_i,
    input wire [15:0] req_wdata_i, rsp_rdata_o,
    // Pins
    input wire [15:0] shared_addr_data_pins_i, shared_addr_data_pins_o,
    input wire shared_addr_data_pins_oe_o, rd_b_o, wr_b_o, ale_o
);
default clocking @(posedge sys_clk_i); endclocking
default disable iff (!rst_b_i);
wire ale_on = ale_o ^ ale_active_low_i;
wire oe = shared_addr_data_pins_oe_o;
sequence s_take; req_valid_i && req_ready_o && port_en_i && !flag_mode_i; endsequence
sequence s_addr; ale_on && oe && shared_addr_data_pins_o == $past(req_addr_i[15:0]); endsequence
property p_take_ale; s_take |=> ale_on; endproperty
a_take_ale: assert property (p_take_ale) else $error("no latch strobe on take");
property p_wide; s_take ##0 wide_mode_i |=> s_addr ##1 !ale_on; endproperty
a_wide: assert property (p_wide) else $error("bad address phase");
property p_rd_oe; !rd_b_o |-> !oe; endproperty
a_rd_oe: assert property (p_rd_oe) else $error("pins driven in read");
property p_rd_end; $rose(rd_b_o) |-> rsp_valid_o; endproperty
a_rd_end: assert property (p_rd_end) else $error("read strobe end");
property p_wr_end; $rose(wr_b_o) |-> rsp_valid_o; endproperty
a_wr_end: assert property (p_wr_end) else $error("write strobe end");
property p_flag; flag_mode_i && $past(flag_mode_i) |-> rd_b_o && wr_b_o && !ale_on; endproperty
a_flag: assert property (p_flag) else $error("strobe in flag use");
property p_off; !port_en_i [*2] |-> !oe; endproperty
a_off: assert property (p_off) else $error("pins driven while off");
property p_idle; ($stable(ale_active_low_i) && req_ready_o) [*3] |-> !ale_on; endproperty
a_idle: assert property (p_idle) else $error("idle strobe level");
endmodule // mpp_port_chk

// file: mpp_port_test.sv
// Self-checking bench for the muxed memory port
`timescale 1ns/1ps
module mpp_port_test;
    reg clk = 0, rst_b = 0, en = 0, flag = 0, wide = 1, pol = 0, valid = 0, wr = 0;
    reg [4:0] ncyc = 5'h05;
    reg [23:0] addr = 24'h000000;
    reg [15:0] wd = 16'h0000;
    wire rdy, rv, oe, rd_b, wr_b, ale;
    wire [15:0] rdata, pin_i, pin_o, last_wr;
    integer n_fail = 0, n_checks = 0, lat, lat1, i;
    always #2.5 clk = ~clk;
    mpp_port dut_u (.sys_clk_i(clk), .rst_b_i(rst_b), .port_en_i(en), .flag_mode_i(flag),
        .wide_mode_i(wide), .ale_active_low_i(pol), .data_cycles_i(ncyc), .req_valid_i(valid),
        .req_write_i(wr), .req_addr_i(addr), .req_wdata_i(wd), .req_ready_o(rdy),
        .rsp_valid_o(rv), .rsp_rdata_o(rdata), .shared_addr_data_pins_i(pin_i),
        .shared_addr_data_pins_o(pin_o), .shared_addr_data_pins_oe_o(oe), .rd_b_o(rd_b),
        .wr_b_o(wr_b), .ale_o(ale));
    mpp_mem_model mem_u (.sys_clk_i(clk), .ale_active_low_i(pol), .oe_i(oe), .rd_b_i(rd_b),
        .wr_b_i(wr_b), .ale_i(ale), .pins_o_i(pin_o), .pins_i_o(pin_i), .last_wr_o(last_wr));
    task check(input [15:0] seen, input [15:0] exp);
        begin
            n_checks = n_checks + 1;
            if (seen !== exp) begin
                n_fail = n_fail + 1;
                $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    task report_and_stop;
        begin
            $display("checks=%0d fails=%0d", n_checks, n_fail);
            if (n_fail == 0 && n_checks > 0) $display("Regression OK");
            else $display("Regression broken");
            $finish;
        end
    endtask
    task step(input integer n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // One access; lat counts edges from take to response
    task access(input w, input [23:0] a, input [15:0] d);
        begin
            wr = w;
            addr = a;
            wd = d;
            valid = 1;
            for (i = 0; rdy !== 1'b1 && i < 50; i = i + 1) step(1);
            step(1);
            valid = 0;
            for (lat = 1; rv !== 1'b1 && lat < 60; lat = lat + 1) step(1);
            if (lat >= 60 || i >= 50) begin
                n_fail = n_fail + 1;
                report_and_stop;
            end
            step(2);
        end
    endtask
    task t_wide;
        begin
            access(1, 24'h00a5c3, 16'hbeef);
            check(last_wr, 16'hbeef);
            access(0, 24'h001234, 16'h0000);
            check(rdata, 16'h486e);
            $display("wide done");
        end
    endtask
    // Upper address change costs one extra latch pulse
    task t_byte;
        begin
            wide = 0;
            access(0, 24'h123456, 16'h0000);
            lat1 = lat;
            access(0, 24'h123457, 16'h0000);
            check(rdata, 16'h000d);
            check(lat1 - lat, 16'h0002);
            wide = 1;
            $display("byte done");
        end
    endtask
    task t_flag;
        begin
            flag = 1;
            valid = 1;
            step(8);
            check(rdy, 16'h0000);
            valid = 0;
            flag = 0;
            pol = 1;
            step(4);
            check(ale, 16'h0001);
            access(1, 24'h000042, 16'h1111);
            check(last_wr, 16'h1111);
            check(oe, 16'h0001);
            en = 0;
            step(3);
            check(oe, 16'h0000);
            $display("flag done");
        end
    endtask
    initial begin
        step(3);
        check({oe, rd_b, wr_b, ale}, 16'h0006);
        rst_b = 1;
        en = 1;
        step(2);
        t_wide;
        t_byte;
        t_flag;
        report_and_stop;
    end
endmodule // mpp_port_test
bind mpp_port mpp_port_chk #(.DATA_CYC_W(DATA_CYC_W)) chk_u (.sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i), .port_en_i(port_en_i), .flag_mode_i(flag_mode_i),
    .wide_mode_i(wide_mode_i), .ale_active_low_i(ale_active_low_i),
    .data_cycles_i(data_cycles_i), .req_valid_i(req_valid_i), .req_write_i(req_write_i),
    .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o), .req_addr_i(req_addr_i),
    .req_wdata_i(req_wdata_i), .rsp_rdata_o(rsp_rdata_o),
    .shared_addr_data_pins_i(shared_addr_data_pins_i),
    .shared_addr_data_pins_o(shared_addr_data_pins_o),
    .shared_addr_data_pins_oe_o(shared_addr_data_pins_oe_o), .rd_b_o(rd_b_o),
    .wr_b_o(wr_b_o), .ale_o(ale_o));
